// ### core/smu_defines.svh
`ifndef SMU_DEFINES_SVH
`define SMU_DEFINES_SVH

// Time base
`define SMU_CLK_PERIOD_NS  100
`define SMU_MS_NS          1000000
`define SMU_TICK_CYCLES    (`SMU_MS_NS / `SMU_CLK_PERIOD_NS)
`define SMU_TICK_W         14
`define SMU_TMR_W          20

// Register byte offsets
`define SMU_ADDR_W         12
`define SMU_OFS_CTRL       12'h000
`define SMU_OFS_WIN        12'h004
`define SMU_OFS_CTO        12'h008
`define SMU_OFS_ENDT       12'h00C
`define SMU_OFS_BLIND      12'h010
`define SMU_OFS_STAT       12'h014

// Control field positions
`define SMU_CTRL_VAR_LSB   0
`define SMU_CTRL_EN_LSB    2
`define SMU_CTRL_DIR_LSB   4
`define SMU_CTRL_CLOSE_BIT 6
`define SMU_CTRL_BLIND_BIT 7
`define SMU_CTRL_RST_BIT   8

// Time settings in ms: reset values and legal ranges
`define SMU_WIN_RST        20'h007D0
`define SMU_WIN_MIN        20'h007D0
`define SMU_WIN_MAX        20'h01388
`define SMU_CTO_RST        20'h02710
`define SMU_CTO_MIN        20'h02710
`define SMU_CTO_MAX        20'hFFFFF
`define SMU_ENDT_RST       20'h009C4
`define SMU_ENDT_MIN       20'h009C4
`define SMU_ENDT_MAX       20'h01770
`define SMU_BLIND_RST      20'h000FA
`define SMU_BLIND_MIN      20'h000FA
`define SMU_BLIND_MAX      20'h003E8

`endif

// ### core/smu_pkg.sv
`include "smu_defines.svh"

package smu_pkg;

   // Muting variant
   typedef enum logic [1:0] {
      SMU_VAR_OPEN, SMU_VAR_BOTH, SMU_VAR_SEQ, SMU_VAR_RSV
   } smu_variant_t;

   // Enable option
   typedef enum logic [1:0] {
      SMU_EN_NONE, SMU_EN_ED, SMU_EN_ONLY, SMU_EN_RSV
   } smu_enmode_t;

   // Travel direction
   typedef enum logic [1:0] {
      SMU_DIR_BI, SMU_DIR_UP, SMU_DIR_DOWN, SMU_DIR_RSV
   } smu_dir_t;

   // Sequencer states
   typedef enum logic [1:0] {
      SMU_ST_IDLE, SMU_ST_FIRST, SMU_ST_MUTE, SMU_ST_BLIND
   } smu_state_t;

   typedef struct packed {
      smu_variant_t variant;
      smu_enmode_t  en_mode;
      smu_dir_t     dir;
      logic         sensor_close;
      logic         blind_en;
   } smu_cfg_t;

   typedef struct packed {
      logic fourth_muting_sensor;
      logic third_muting_sensor;
      logic second_muting_sensor;
      logic first_muting_sensor;
   } smu_sense_t;

   typedef struct packed {
      logic [`SMU_TMR_W-1:0] win;
      logic [`SMU_TMR_W-1:0] cto;
      logic [`SMU_TMR_W-1:0] endt;
      logic [`SMU_TMR_W-1:0] blind;
   } smu_times_t;

endpackage

// ### core/smu_muting.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`include "smu_defines.svh"

module smu_muting #(
   parameter int TICK_CYCLES = `SMU_TICK_CYCLES
) (
   input  wire logic                   pclk,           // Clock, 10 MHz
   input  wire logic                   presetn,        // Async reset
   input  wire logic                   psel,           // APB select
   input  wire logic                   penable,        // APB enable
   input  wire logic                   pwrite,         // APB direction
   input  wire logic [`SMU_ADDR_W-1:0] paddr,          // APB address
   input  wire logic [31:0]            pwdata,         // APB write data
   output logic      [31:0]            prdata,         // APB read data
   output logic                        pready,         // APB ready
   output logic                        pslverr,        // APB error
   input  smu_pkg::smu_sense_t         sensors,        // Muting sensors
   input  wire logic                   protect_in,     // Light grid
   input  wire logic                   mute_enable_in, // Enable line
   output logic                        safe_out,       // Muted output
   output logic                        muting_active   // Muting state
);
   import smu_pkg::*;

   smu_cfg_t                   cfg_reg;
   smu_times_t                 tm_reg;
   smu_state_t                 state_reg;
   smu_state_t                 state_next;
   logic [`SMU_TICK_W-1:0]     tick_cnt_reg;
   logic                       tick_reg;
   logic [`SMU_TMR_W-1:0]      phase_ms_reg;
   logic [`SMU_TMR_W-1:0]      cycle_ms_reg;
   logic                       en_prev_reg;
   logic                       prot_prev_reg;
   logic                       armed_reg;
   logic                       ready_reg;
   logic                       dir_down_reg;
   logic                       dir_down_next;
   logic                       gone_reg;
   logic                       seen3_reg;
   logic                       phase_clr;
   logic                       gone_set;
   logic                       mute_end;
   logic                       blind_ok;
   logic                       cyc_expired;
   logic                       en_rise;
   logic                       en_fall;
   logic                       en_cancel;
   logic                       cfg_wr;
   logic                       wr_en;
   logic                       hit;
   logic [31:0]                rd_val;
   logic [3:0]                 s;
   logic [3:0]                 ord;
   logic                       safe_out_reg;
   logic                       muting_reg;
   logic [31:0]                prdata_reg;
   logic                       pready_reg;
   logic                       pslverr_reg;

   // Clamp a written time into its legal range
   function automatic logic [`SMU_TMR_W-1:0] clamp(
      input logic [31:0]            v,
      input logic [`SMU_TMR_W-1:0]  lo,
      input logic [`SMU_TMR_W-1:0]  hi);
      logic [`SMU_TMR_W-1:0] r;
      if (v < 32'(lo)) begin
         r = lo;
      end else if (v > 32'(hi)) begin
         r = hi;
      end else begin
         r = v[`SMU_TMR_W-1:0];
      end
      return r;
   endfunction

   assign s = {sensors.fourth_muting_sensor, sensors.third_muting_sensor,
               sensors.second_muting_sensor, sensors.first_muting_sensor};

   // Sensors reordered along the travel direction
   generate
      for (genvar i = 0; i < 4; i++) begin : g_ord
         assign ord[i] = dir_down_reg ? s[3-i] : s[i];
      end
   endgenerate

   // APB decode: zero-wait access, write at the completing edge
   assign wr_en  = psel && penable && pready_reg && pwrite;
   assign cfg_wr = wr_en && (paddr == `SMU_OFS_CTRL);

   always_comb begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         `SMU_OFS_CTRL: begin
            rd_val[1:0] = cfg_reg.variant;
            rd_val[3:2] = cfg_reg.en_mode;
            rd_val[5:4] = cfg_reg.dir;
            rd_val[6]   = cfg_reg.sensor_close;
            rd_val[7]   = cfg_reg.blind_en;
         end
         `SMU_OFS_WIN:   rd_val[`SMU_TMR_W-1:0] = tm_reg.win;
         `SMU_OFS_CTO:   rd_val[`SMU_TMR_W-1:0] = tm_reg.cto;
         `SMU_OFS_ENDT:  rd_val[`SMU_TMR_W-1:0] = tm_reg.endt;
         `SMU_OFS_BLIND: rd_val[`SMU_TMR_W-1:0] = tm_reg.blind;
         `SMU_OFS_STAT: begin
            rd_val[1:0]  = state_reg;
            rd_val[2]    = safe_out_reg;
            rd_val[3]    = muting_reg;
            rd_val[4]    = armed_reg;
            rd_val[5]    = ready_reg;
            rd_val[6]    = dir_down_reg;
            rd_val[11:8] = s;
            rd_val[12]   = protect_in;
         end
         default: hit = 1'b0;
      endcase
   end

   // Bus answer registers, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= psel && !penable;
         if (psel && !penable) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_reg <= !hit || (pwrite && paddr == `SMU_OFS_STAT);
         end
      end
   end

   // Configuration and time setting registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg  <= '0;
         tm_reg   <= {`SMU_WIN_RST, `SMU_CTO_RST, `SMU_ENDT_RST,
                      `SMU_BLIND_RST};
      end else if (wr_en) begin
         case (paddr)
            `SMU_OFS_CTRL: begin
               cfg_reg.variant <= smu_variant_t'(
                  pwdata[`SMU_CTRL_VAR_LSB +: 2]);
               cfg_reg.en_mode <= smu_enmode_t'(
                  pwdata[`SMU_CTRL_EN_LSB +: 2]);
               cfg_reg.dir <= smu_dir_t'(pwdata[`SMU_CTRL_DIR_LSB +: 2]);
               cfg_reg.sensor_close <= pwdata[`SMU_CTRL_CLOSE_BIT];
               cfg_reg.blind_en     <= pwdata[`SMU_CTRL_BLIND_BIT];
            end
            `SMU_OFS_WIN:
               tm_reg.win <= clamp(pwdata, `SMU_WIN_MIN, `SMU_WIN_MAX);
            `SMU_OFS_CTO:
               tm_reg.cto <= (pwdata == 32'h0000_0000) ? '0 :
                  clamp(pwdata, `SMU_CTO_MIN, `SMU_CTO_MAX);
            `SMU_OFS_ENDT:
               tm_reg.endt <= clamp(pwdata, `SMU_ENDT_MIN, `SMU_ENDT_MAX);
            `SMU_OFS_BLIND:
               tm_reg.blind <= clamp(pwdata, `SMU_BLIND_MIN,
                                     `SMU_BLIND_MAX);
            default: ;
         endcase
      end
   end

   // Millisecond time base
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == `SMU_TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
         tick_reg     <= 1'b0;
      end
   end

   // Edge detection of enable and protective input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_prev_reg   <= 1'b0;
         prot_prev_reg <= 1'b1;  // Grid idles clear, no false rise
      end else begin
         en_prev_reg   <= mute_enable_in;
         prot_prev_reg <= protect_in;
      end
   end

   assign en_rise = mute_enable_in && !en_prev_reg;
   assign en_fall = !mute_enable_in && en_prev_reg;
   // falling-edge cancel only in enable-disable mode
   assign en_cancel   = (cfg_reg.en_mode == SMU_EN_ED) && en_fall;
   assign cyc_expired = (tm_reg.cto != '0) && (cycle_ms_reg >= tm_reg.cto);
   // blind time refused for sequential sensor closing
   assign blind_ok = cfg_reg.blind_en &&
      !(cfg_reg.variant == SMU_VAR_SEQ && cfg_reg.sensor_close);
   assign gone_set = (state_reg == SMU_ST_MUTE) &&
      (cfg_reg.variant == SMU_VAR_OPEN) && !gone_reg && !(s[0] && s[1]);

   // End-of-muting condition per variant
   always_comb begin
      case (cfg_reg.variant)
         // opening clear or end time after first clear
         SMU_VAR_OPEN: mute_end = gone_reg && ((!s[0] && !s[1] &&
            protect_in) || phase_ms_reg >= tm_reg.endt);
         SMU_VAR_BOTH: mute_end = !s[0] && !s[1];
         // curtain rising input or penultimate clear
         SMU_VAR_SEQ:  mute_end = cfg_reg.sensor_close ?
            (seen3_reg && !ord[2]) : (protect_in && !prot_prev_reg);
         default:      mute_end = 1'b0;
      endcase
   end

   // Sequencer next state
   always_comb begin
      state_next    = state_reg;
      dir_down_next = dir_down_reg;
      case (state_reg)
         SMU_ST_IDLE: begin
            // start gated by ready, armed, input
            if (ready_reg && armed_reg && protect_in) begin
               if (cfg_reg.variant == SMU_VAR_SEQ) begin
                  if (s[0] && cfg_reg.dir != SMU_DIR_DOWN) begin
                     state_next    = SMU_ST_FIRST;
                     dir_down_next = 1'b0;
                  end else if (s[3] && cfg_reg.dir != SMU_DIR_UP) begin
                     state_next    = SMU_ST_FIRST;
                     dir_down_next = 1'b1;
                  end
               end else if (s[0] || s[1]) begin
                  state_next = (s[0] && s[1]) ? SMU_ST_MUTE : SMU_ST_FIRST;
               end
            end
         end
         SMU_ST_FIRST: begin
            if (cyc_expired || en_cancel) begin
               state_next = SMU_ST_IDLE;
            end else if (cfg_reg.variant == SMU_VAR_SEQ) begin
               if (!ord[0] || ord[2] || ord[3]) begin
                  state_next = SMU_ST_IDLE;
               end else if (ord[1]) begin
                  state_next = SMU_ST_MUTE;
               end
            end else if (s[0] && s[1]) begin
               state_next = SMU_ST_MUTE;
            end else if (!(s[0] || s[1]) ||
                         phase_ms_reg >= tm_reg.win) begin
               state_next = SMU_ST_IDLE;
            end
         end
         SMU_ST_MUTE: begin
            if (cyc_expired || en_cancel) begin
               state_next = SMU_ST_IDLE;
            end else if (mute_end) begin
               state_next = blind_ok ? SMU_ST_BLIND : SMU_ST_IDLE;
            end
         end
         SMU_ST_BLIND: begin
            if (phase_ms_reg >= tm_reg.blind) begin
               state_next = SMU_ST_IDLE;
            end
         end
         default: state_next = SMU_ST_IDLE;
      endcase
   end

   assign phase_clr = (state_next != state_reg) || gone_set;

   // State register; a control write returns to idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= SMU_ST_IDLE;
         dir_down_reg <= 1'b0;
      end else if (cfg_wr) begin
         state_reg    <= SMU_ST_IDLE;
         dir_down_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         dir_down_reg <= dir_down_next;
      end
   end

   // Phase and cycle timers in ms, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ms_reg <= '0;
         cycle_ms_reg <= '0;
      end else begin
         if (phase_clr || cfg_wr) begin
            phase_ms_reg <= '0;
         end else if (tick_reg && phase_ms_reg != '1) begin
            phase_ms_reg <= phase_ms_reg + 1'b1;
         end
         if (state_next == SMU_ST_IDLE || state_next == SMU_ST_BLIND ||
             cfg_wr) begin
            cycle_ms_reg <= '0;
         end else if (tick_reg && cycle_ms_reg != '1) begin
            cycle_ms_reg <= cycle_ms_reg + 1'b1;
         end
      end
   end

   // Sensor history within muting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gone_reg  <= 1'b0;
         seen3_reg <= 1'b0;
      end else if (state_reg != SMU_ST_MUTE) begin
         gone_reg  <= 1'b0;
         seen3_reg <= 1'b0;
      end else begin
         if (gone_set) begin
            gone_reg <= 1'b1;
         end
         if (ord[2]) begin
            seen3_reg <= 1'b1;
         end
      end
   end

   // ready means all relevant sensors clear, input true
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= (state_next == SMU_ST_IDLE) && !cfg_wr &&
            protect_in && ((cfg_reg.variant == SMU_VAR_SEQ) ?
            (s == 4'h0) : (s[1:0] == 2'h0));
      end
   end

   // arming by enable edge; a rise beats any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
      end else if (en_rise) begin
         armed_reg <= 1'b1;
      end else if (cfg_wr) begin
         armed_reg <= 1'b0;  // Config reset disarms, even from none mode
      end else if (cfg_reg.en_mode == SMU_EN_NONE) begin
         armed_reg <= 1'b1;
      end else if (en_cancel || (state_reg == SMU_ST_IDLE &&
                   state_next != SMU_ST_IDLE)) begin
         armed_reg <= 1'b0;
      end
   end

   // output forced true while muting or blind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         safe_out_reg <= 1'b0;
         muting_reg   <= 1'b0;
      end else begin
         safe_out_reg <= protect_in || (!cfg_wr &&
            (state_next == SMU_ST_MUTE || state_next == SMU_ST_BLIND));
         muting_reg   <= !cfg_wr && (state_next == SMU_ST_MUTE);
      end
   end

   assign safe_out      = safe_out_reg;
   assign muting_active = muting_reg;
   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;

   a_out_forced: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_reg == SMU_ST_MUTE || state_reg == SMU_ST_BLIND) |-> safe_out)
      else $error("output not forced during muting");

   a_idle_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_reg == SMU_ST_IDLE && $past(presetn)) |->
      safe_out == $past(protect_in))
      else $error("idle output does not follow input");

   a_start_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_reg == SMU_ST_IDLE && state_next != SMU_ST_IDLE) |->
      (ready_reg && armed_reg && protect_in))
      else $error("cycle started without ready and armed");

   a_window_bound: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_reg == SMU_ST_FIRST && cfg_reg.variant != SMU_VAR_SEQ) |->
      phase_ms_reg <= tm_reg.win)
      else $error("sensor window overrun");

   a_cycle_bound: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tm_reg.cto != '0 && state_reg == SMU_ST_MUTE && cyc_expired) |=>
      state_reg == SMU_ST_IDLE)
      else $error("cycle timeout not enforced");

   a_fall_cancel: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.en_mode == SMU_EN_ED && $fell(mute_enable_in) &&
       state_reg == SMU_ST_MUTE && !cfg_wr) |=> state_reg == SMU_ST_IDLE)
      else $error("enable fall did not cancel muting");

   a_both_end: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.variant == SMU_VAR_BOTH && state_reg == SMU_ST_MUTE &&
       !s[0] && !s[1]) |=> state_reg != SMU_ST_MUTE)
      else $error("muting kept after both sensors clear");

   a_blind_seq: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.variant == SMU_VAR_SEQ && cfg_reg.sensor_close) |->
      state_reg != SMU_ST_BLIND)
      else $error("blind time with sensor closing");

   a_dir_up: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_reg.variant == SMU_VAR_SEQ && cfg_reg.dir == SMU_DIR_UP &&
       state_reg == SMU_ST_IDLE && state_next != SMU_ST_IDLE) |=>
      !dir_down_reg)
      else $error("down travel accepted in up mode");

endmodule // smu_muting

// ### dv/smu_field.sv
`timescale 1ns/10ps
module smu_field (
   input  wire logic           pclk,           // Clock
   output smu_pkg::smu_sense_t sensors,        // Muting sensors
   output logic                protect_in,     // Light grid, 1 = clear
   output logic                mute_enable_in  // Enable line
);
   import smu_pkg::*;

   // Field starts empty with the grid clear
   initial begin
      sensors        = '0;
      protect_in     = 1'b1;
      mute_enable_in = 1'b0;
   end

   // Move the field just after an edge, then let it rest for gap cycles
   task automatic put(input logic [3:0] s, input logic p, input logic e,
                      input int gap);
      @(posedge pclk);
      sensors    <= smu_sense_t'(s);
      protect_in <= p;
      mute_enable_in <= e;
      repeat (gap) @(posedge pclk);
   endtask
endmodule // smu_field

// ### dv/testbench.sv
`timescale 1ns/10ps
`include "smu_defines.svh"
module testbench;
   import smu_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, link_stb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd, exp_w;
   logic        pready, pslverr, safe_out, muting_active;
   logic        protect_in, mute_enable_in;
   smu_sense_t  sensors;
   logic [33:0] notes[$];
   int          err_count, compares, seed;

   smu_muting #(.TICK_CYCLES(10)) u_smu_muting (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sensors(sensors),
      .protect_in(protect_in), .mute_enable_in(mute_enable_in),
      .safe_out(safe_out), .muting_active(muting_active));

   smu_field u_smu_field (
      .pclk(pclk), .sensors(sensors), .protect_in(protect_in),
      .mute_enable_in(mute_enable_in));

   // Clock, 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp_apb(input logic [33:0] n);
      compares++;
      if (pslverr !== n[32] || (!n[33] && prdata !== n[31:0])) begin
         err_count++;
         $display("[ERR] %0t exp %h got %h", $time, n[32:0],
                  {pslverr, prdata});
      end
   endtask

   task automatic cmp_link(input logic [33:0] n);
      compares++;
      if ({muting_active, safe_out} !== n[1:0]) begin
         err_count++;
         $display("[ERR] %0t exp %h got %h", $time, n[1:0],
                  {muting_active, safe_out});
      end
   endtask

   // Results are checked mid-cycle, where they are settled
   always @(negedge pclk) begin
      if (psel && penable && pready)
         cmp_apb(notes.pop_front());
      if (link_stb)
         cmp_link(notes.pop_front());
   end

   // One APB transfer; note holds direction, error and read data
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic er,
                      input logic [31:0] ex);
      notes.push_back({wr, er, ex});
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      @(negedge pclk);
      while (pready !== 1'b1)
         @(negedge pclk);
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Set the field, wait, then expect muting and output levels
   task automatic step(input logic [3:0] s, input logic p, input logic e,
                       input logic m, input logic o);
      u_smu_field.put(s, p, e, 4);
      notes.push_back({32'h0, m, o});
      link_stb <= 1'b1;
      @(posedge pclk);
      link_stb <= 1'b0;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      repeat (70000) @(posedge pclk);
      err_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      seed = 32'h5414;
      {presetn, psel, penable, pwrite, link_stb} = 5'h0;
      paddr  = 12'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `SMU_OFS_CTRL, 0, 0, 32'h0);
      apb(0, `SMU_OFS_ENDT, 0, 0, 32'h9C4);
      apb(0, `SMU_OFS_BLIND, 0, 0, 32'hFA);
      apb(0, 12'h020, 0, 1, 32'h0);
      apb(1, `SMU_OFS_STAT, 32'hF, 1, 32'h0);
      rnd = $random(seed) & 32'h1FFF;
      exp_w = rnd;
      if (rnd < 32'h7D0) exp_w = 32'h7D0;
      if (rnd > 32'h1388) exp_w = 32'h1388;
      apb(1, `SMU_OFS_WIN, rnd, 0, 32'h0);
      apb(0, `SMU_OFS_WIN, 0, 0, exp_w);
      apb(1, `SMU_OFS_WIN, 32'h7D0, 0, 32'h0);
      apb(1, `SMU_OFS_CTO, 32'h0, 0, 32'h0);
      $display("registers done");
      step(4'h0, 0, 0, 0, 0);
      step(4'h0, 1, 0, 0, 1);
      step(4'h2, 1, 0, 0, 1);
      step(4'h3, 1, 0, 1, 1);
      step(4'h3, 0, 0, 1, 1);
      step(4'h1, 1, 0, 1, 1);
      step(4'h0, 1, 0, 0, 1);
      $display("opening variant done");
      apb(1, `SMU_OFS_CTRL, 32'h81, 0, 32'h0);
      step(4'h0, 0, 0, 0, 0);
      step(4'h3, 0, 0, 0, 0);
      step(4'h0, 1, 0, 0, 1);
      step(4'h1, 1, 0, 0, 1);
      step(4'h3, 1, 0, 1, 1);
      step(4'h3, 0, 0, 1, 1);
      step(4'h0, 0, 0, 0, 1);
      repeat (2300) @(posedge pclk);
      step(4'h0, 0, 0, 0, 1);
      repeat (300) @(posedge pclk);
      step(4'h0, 0, 0, 0, 0);
      step(4'h0, 1, 0, 0, 1);
      step(4'h1, 1, 0, 0, 1);
      repeat (21000) @(posedge pclk);
      step(4'h3, 1, 0, 0, 1);
      step(4'h0, 1, 1, 0, 1);
      $display("clear variant done");
      apb(1, `SMU_OFS_CTRL, 32'h05, 0, 32'h0);
      step(4'h3, 1, 1, 0, 1);
      step(4'h0, 1, 0, 0, 1);
      step(4'h0, 1, 1, 0, 1);
      step(4'h3, 1, 1, 1, 1);
      step(4'h3, 1, 0, 0, 1);
      step(4'h0, 1, 0, 0, 1);
      apb(1, `SMU_OFS_CTRL, 32'h09, 0, 32'h0);
      step(4'h0, 1, 1, 0, 1);
      step(4'h3, 1, 1, 1, 1);
      step(4'h3, 1, 0, 1, 1);
      step(4'h0, 1, 0, 0, 1);
      $display("enable modes done");
      apb(1, `SMU_OFS_CTRL, 32'h52, 0, 32'h0);
      step(4'h8, 1, 0, 0, 1);
      step(4'hC, 1, 0, 0, 1);
      step(4'h0, 1, 0, 0, 1);
      step(4'h1, 0, 0, 0, 0);
      step(4'h3, 1, 0, 0, 1);
      step(4'h0, 1, 0, 0, 1);
      step(4'h1, 1, 0, 0, 1);
      step(4'h3, 1, 0, 1, 1);
      step(4'hF, 0, 0, 1, 1);
      step(4'hC, 1, 0, 1, 1);
      step(4'h8, 1, 0, 0, 1);
      step(4'h0, 1, 0, 0, 1);
      $display("sequential done");
      // Sequential, bidirectional, curtain closing, travel four to one
      apb(1, `SMU_OFS_CTRL, 32'h02, 0, 32'h0);
      step(4'h0, 1, 0, 0, 1);
      step(4'h8, 1, 0, 0, 1);
      step(4'hC, 1, 0, 1, 1);
      step(4'hC, 0, 0, 1, 1);
      step(4'h3, 1, 0, 0, 1);
      step(4'h0, 1, 0, 0, 1);
      $display("curtain done");
      // Opening-clear variant ended by the end muting time
      apb(1, `SMU_OFS_CTRL, 32'h00, 0, 32'h0);
      step(4'h0, 1, 0, 0, 1);
      step(4'h3, 1, 0, 1, 1);
      step(4'h1, 0, 0, 1, 1);
      repeat (25100) @(posedge pclk);
      step(4'h1, 0, 0, 0, 0);
      step(4'h0, 1, 0, 0, 1);
      $display("end time done");
      wrap_up();
   end
endmodule // testbench
